// ---- core/usb_dc_pkg.sv ----
// Purpose: shared constants, types and decode helpers for the device-controller command link
// Assumes: one clock, 16-bit command/data link between the two ends
// Notes: host-side order registers are byte addressed, four apart, on classic Wishbone
package usb_dc_pkg;
    localparam int DATA_W = 16;
    localparam int PTR_W = 10;
    // Command codes
    localparam logic [7:0] CMD_CFG_WR = 8'hf0;
    localparam logic [7:0] CMD_CFG_RD = 8'hf1;
    localparam logic [7:0] CMD_CNT_WR = 8'hf2;
    localparam logic [7:0] CMD_CNT_RD = 8'hf3;
    localparam logic [7:0] CMD_DEV_RESET = 8'hf6;
    localparam logic [7:0] CMD_BUF_WR_LO = 8'h01;
    localparam logic [7:0] CMD_BUF_WR_HI = 8'h0f;
    localparam logic [7:0] CMD_BUF_RD_LO = 8'h10;
    localparam logic [7:0] CMD_BUF_RD_GAP = 8'h11;
    localparam logic [7:0] CMD_BUF_RD_HI = 8'h1f;
    localparam logic [7:0] CMD_STAT_LO = 8'h50;
    localparam logic [7:0] CMD_STAT_HI = 8'h5f;
    // dma_configuration fields
    localparam int CFG_CNT_END_BIT = 15;
    localparam int CFG_SHORT_BIT = 14;
    localparam int CFG_WIDTH_BIT = 8;
    localparam int CFG_EP_LSB = 4;
    localparam int CFG_EN_BIT = 3;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WR_MASK = 16'hfeff;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // Bytes per access and per burst
    localparam logic [4:0] BYTE_BYTES = 5'h01;
    localparam logic [4:0] WORD_BYTES = 5'h02;
    localparam logic [4:0] BURST_BYTES_1 = 5'h01;
    localparam logic [4:0] BURST_BYTES_4 = 5'h04;
    localparam logic [4:0] BURST_BYTES_8 = 5'h08;
    localparam logic [4:0] BURST_BYTES_16 = 5'h10;
    // Buffer limits: M = (N + 1) / 2, one access moves M + 1 words
    localparam int ISO_MAX_BYTES = 1023;
    localparam int BULK_MAX_BYTES = 32;
    localparam int BUF_MAX_WORDS = (ISO_MAX_BYTES + 1) / 2 + 1;
    // Host order registers
    localparam logic [4:0] WB_CMD = 5'h00;
    localparam logic [4:0] WB_WDATA = 5'h04;
    localparam logic [4:0] WB_RDATA = 5'h08;
    localparam logic [4:0] WB_STATUS = 5'h0c;
    localparam logic [4:0] WB_DMA = 5'h10;
    localparam int ST_DREQ = 0;
    localparam int ST_EOT = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_IN_DIR = 3;
    localparam int ST_EXT_EOT = 4;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_WAIT = 3'b010,
        H_ACK = 3'b100
    } host_state_t;

    function automatic logic is_buf_wr(input logic [7:0] c);
        return (c >= CMD_BUF_WR_LO) && (c <= CMD_BUF_WR_HI);
    endfunction

    function automatic logic is_buf_rd(input logic [7:0] c);
        return (c >= CMD_BUF_RD_LO) && (c <= CMD_BUF_RD_HI) && (c != CMD_BUF_RD_GAP);
    endfunction

    function automatic logic is_stat(input logic [7:0] c);
        return (c >= CMD_STAT_LO) && (c <= CMD_STAT_HI);
    endfunction

    function automatic logic is_one_word(input logic [7:0] c);
        return (c == CMD_CFG_WR) || (c == CMD_CFG_RD) || (c == CMD_CNT_WR) || (c == CMD_CNT_RD);
    endfunction
endpackage

// ---- core/usb_dc_link_if.sv ----
// Purpose: command/data and DMA link between microprocessor end and device end
// Assumes: both ends on the same clock; strobes are one-cycle pulses
// Notes: data runs on separate in and out buses, no shared wire
`timescale 1ns/1ps
interface usb_dc_link_if;
    logic cmd_sel;
    logic wr_strobe;
    logic rd_strobe;
    logic dma_ack;
    logic eot_host;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic dma_req;
    logic eot_dev;

    modport dev_mp (
        input cmd_sel, wr_strobe, rd_strobe, dma_ack, eot_host, wdata,
        output rdata, rvalid, dma_req, eot_dev
    );
    modport host_mp (
        output cmd_sel, wr_strobe, rd_strobe, dma_ack, eot_host, wdata,
        input rdata, rvalid, dma_req, eot_dev
    );
endinterface

// ---- core/usb_dc_burst.sv ----
// Purpose: counts bytes of a DMA burst and flags its end
// Assumes: access_i is a one-cycle pulse per DMA word or byte
// Notes: a word access can overshoot a one-byte burst; it still ends it
`timescale 1ns/1ps
module usb_dc_burst
    import usb_dc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [1:0] burst_sel_i,
    input wire logic access_i,
    input wire logic [4:0] moved_i,
    output logic burst_end_o
);
    logic [4:0] limit;
    logic [4:0] bytes_r;
    logic [5:0] sum;

    always_comb begin
        unique case (burst_sel_i)
            2'b00: limit = BURST_BYTES_1;
            2'b01: limit = BURST_BYTES_4;
            2'b10: limit = BURST_BYTES_8;
            2'b11: limit = BURST_BYTES_16;
        endcase
    end

    assign sum = {1'b0, bytes_r} + {1'b0, moved_i};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bytes_r <= 5'h00;
            burst_end_o <= 1'b0;
        end else if (access_i && (sum >= {1'b0, limit})) begin
            bytes_r <= 5'h00;
            burst_end_o <= 1'b1;
        end else if (access_i) begin
            bytes_r <= sum[4:0];
            burst_end_o <= 1'b0;
        end else begin
            burst_end_o <= 1'b0;
        end
    end
endmodule

// ---- core/usb_dc_dev_end.sv ----
// Purpose: device end: command decode, DMA control and endpoint buffer access
// Assumes: endpoint storage outside, read combinationally at buf_addr_o
// Notes: CPU and DMA share one buffer pointer
// Contract
// - Counter end enable: end-of-transfer at zero count
// - Short packet mode: short OUT packet ends transfer
// - Host keeps short mode clear for IN
// - Width flag: 0 byte, 1 word last access
// - Enable bit starts, clear stops, reads state
// - Bus reset clears only the enable bit
// - Burst code selects 1, 4, 8, 16 bytes
// - Endpoint index field selects DMA buffer
// - Counter write sets count, read gives remaining
// - Re-enable reloads working counter from programmed
// - Counter read F3, write F2, one word
// - Configuration read F1, write F0, one word
// - Code F6 resets controller like hardware reset
// - Buffer command resets pointer, words advance it
// - Buffer codes on low byte, then data
// - Buffer size limits; at most M+1 words
// - Word 0 length, data low byte first
// - DMA skips length word, ends on EOP
// - IN sent when full or external stop
// - Host never reverses direction after buffer command
// - No bounds guard; DMA moves to secondary buffer
// - Status codes 50-5F read, clear pending bit
`timescale 1ns/1ps
module usb_dc_dev_end
    import usb_dc_pkg::*;
#(
    parameter int PW = PTR_W
)(
    input wire logic clock_i,
    input wire logic rstn_i,
    usb_dc_link_if.dev_mp lnk,
    input wire logic usb_reset_i,
    input wire logic short_pkt_i,
    input wire logic buf_eop_i,
    input wire logic ep_double_i,
    input wire logic [PW-1:0] ep_words_i,
    input wire logic [15:0] buf_rdata_i,
    input wire logic [7:0] ep_status_i,
    output logic [3:0] buf_ep_o,
    output logic [PW-1:0] buf_addr_o,
    output logic [PW-1:0] buf_waddr_o,
    output logic buf_sec_o,
    output logic buf_we_o,
    output logic [15:0] buf_wdata_o,
    output logic buf_commit_o,
    output logic status_clr_o,
    output logic ctrl_reset_o
);
    localparam logic [PW-1:0] FIRST_DATA_WORD = {{(PW-1){1'b0}}, 1'b1};

    logic rst;
    logic soft_rst_r;
    logic [7:0] cmd_r;
    logic [15:0] cfg_r;
    logic [15:0] cnt_prog_r;
    logic [15:0] cnt_work_r;
    logic [15:0] rdata_r;
    logic [15:0] wdata_r;
    logic [3:0] ep_r;
    logic [PW-1:0] ptr_r;
    logic [PW-1:0] waddr_r;
    logic sec_r;
    logic rvalid_r;
    logic dreq_r;
    logic eot_r;
    logic we_r;
    logic commit_r;
    logic stat_clr_r;
    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic dma_wr;
    logic dma_rd;
    logic dma_acc;
    logic dma_en;
    logic cfg_wr;
    logic cnt_wr;
    logic en_rise;
    logic cnt_hit;
    logic short_hit;
    logic ext_hit;
    logic stop;
    logic prim_end;
    logic cpu_buf;
    logic burst_end;
    logic [4:0] moved;
    logic [15:0] moved_w;

    // Soft reset acts one cycle after the command, like the reset pin
    assign rst = !rstn_i || soft_rst_r;
    assign dma_en = cfg_r[CFG_EN_BIT];
    assign cmd_wr = lnk.wr_strobe && lnk.cmd_sel && !lnk.dma_ack;
    assign data_wr = lnk.wr_strobe && !lnk.cmd_sel && !lnk.dma_ack;
    assign data_rd = lnk.rd_strobe && !lnk.cmd_sel && !lnk.dma_ack;
    assign dma_wr = lnk.dma_ack && lnk.wr_strobe && dma_en;
    assign dma_rd = lnk.dma_ack && lnk.rd_strobe && dma_en;
    assign dma_acc = dma_wr || dma_rd;
    assign cfg_wr = data_wr && (cmd_r == CMD_CFG_WR);
    assign cnt_wr = data_wr && (cmd_r == CMD_CNT_WR);
    assign en_rise = cfg_wr && lnk.wdata[CFG_EN_BIT] && !dma_en;
    assign cpu_buf = (data_wr && is_buf_wr(cmd_r)) || (data_rd && is_buf_rd(cmd_r));
    // An odd final byte moves alone; every other access is a word
    assign moved = (cnt_work_r == 16'h0001) ? BYTE_BYTES : WORD_BYTES;
    assign moved_w = {11'h000, moved};
    assign cnt_hit = cfg_r[CFG_CNT_END_BIT] && dma_acc && (cnt_work_r <= moved_w);
    assign short_hit = cfg_r[CFG_SHORT_BIT] && dma_en && short_pkt_i;
    assign ext_hit = dma_en && lnk.eot_host;
    assign stop = cnt_hit || short_hit || ext_hit;
    assign prim_end = dma_acc && ((ptr_r == ep_words_i) || (dma_rd && buf_eop_i));

    usb_dc_burst u_burst (
        .clock_i(clock_i),
        .rst_i(rst),
        .burst_sel_i(cfg_r[1:0]),
        .access_i(dma_acc),
        .moved_i(moved),
        .burst_end_o(burst_end)
    );

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= cmd_wr && (lnk.wdata[7:0] == CMD_DEV_RESET);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            cmd_r <= 8'h00;
        end else if (cmd_wr) begin
            cmd_r <= lnk.wdata[7:0];
        end
    end

    // Later assignments win: stop and bus reset override a write of 1
    always_ff @(posedge clock_i) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
        end else begin
            if (cfg_wr) begin
                cfg_r <= (lnk.wdata & CFG_WR_MASK) | (cfg_r & ~CFG_WR_MASK);
            end
            if (dma_acc) begin
                cfg_r[CFG_WIDTH_BIT] <= (moved == WORD_BYTES);
            end
            if (stop || usb_reset_i) begin
                cfg_r[CFG_EN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            cnt_prog_r <= CNT_RESET;
        end else if (cnt_wr) begin
            cnt_prog_r <= lnk.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            cnt_work_r <= CNT_RESET;
        end else if (en_rise) begin
            cnt_work_r <= cnt_prog_r;
        end else if (cnt_wr && !dma_en) begin
            cnt_work_r <= lnk.wdata;
        end else if (dma_acc && (cnt_work_r > moved_w)) begin
            cnt_work_r <= cnt_work_r - moved_w;
        end else if (dma_acc) begin
            cnt_work_r <= 16'h0000;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            ep_r <= 4'h0;
            ptr_r <= {PW{1'b0}};
            sec_r <= 1'b0;
        end else if (cmd_wr && (is_buf_wr(lnk.wdata[7:0]) || is_buf_rd(lnk.wdata[7:0])
                     || is_stat(lnk.wdata[7:0]))) begin
            ep_r <= lnk.wdata[3:0];
            ptr_r <= {PW{1'b0}};
            sec_r <= 1'b0;
        end else if (en_rise) begin
            ep_r <= lnk.wdata[CFG_EP_LSB +: 4];
            ptr_r <= FIRST_DATA_WORD;
            sec_r <= 1'b0;
        end else if (prim_end) begin
            ptr_r <= FIRST_DATA_WORD;
            sec_r <= ep_double_i ? !sec_r : sec_r;
        end else if (dma_acc || cpu_buf) begin
            // No bound check: software owns the buffer size
            ptr_r <= ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= data_rd || dma_rd;
            if (dma_rd) begin
                rdata_r <= buf_rdata_i;
            end else if (data_rd && (cmd_r == CMD_CFG_RD)) begin
                rdata_r <= cfg_r;
            end else if (data_rd && (cmd_r == CMD_CNT_RD)) begin
                rdata_r <= cnt_work_r;
            end else if (data_rd && is_buf_rd(cmd_r)) begin
                rdata_r <= buf_rdata_i;
            end else if (data_rd && is_stat(cmd_r)) begin
                rdata_r <= {8'h00, ep_status_i};
            end else if (data_rd) begin
                rdata_r <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            we_r <= 1'b0;
            wdata_r <= 16'h0000;
            waddr_r <= {PW{1'b0}};
            stat_clr_r <= 1'b0;
        end else begin
            we_r <= dma_wr || (data_wr && is_buf_wr(cmd_r));
            stat_clr_r <= data_rd && is_stat(cmd_r);
            if (dma_wr || data_wr) begin
                wdata_r <= lnk.wdata;
                waddr_r <= ptr_r;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst) begin
            eot_r <= 1'b0;
            commit_r <= 1'b0;
            dreq_r <= 1'b0;
        end else begin
            eot_r <= stop;
            commit_r <= prim_end || ext_hit;
            // Request drops for one cycle between bursts
            dreq_r <= dma_en && !stop && !usb_reset_i && !burst_end && !cfg_wr
                      && !(cfg_r[CFG_CNT_END_BIT] && (cnt_work_r == 16'h0000));
        end
    end

    assign lnk.rdata = rdata_r;
    assign lnk.rvalid = rvalid_r;
    assign lnk.dma_req = dreq_r;
    assign lnk.eot_dev = eot_r;
    assign buf_ep_o = ep_r;
    assign buf_addr_o = ptr_r;
    assign buf_waddr_o = waddr_r;
    assign buf_sec_o = sec_r;
    assign buf_we_o = we_r;
    assign buf_wdata_o = wdata_r;
    assign buf_commit_o = commit_r;
    assign status_clr_o = stat_clr_r;
    assign ctrl_reset_o = soft_rst_r;
endmodule

// ---- core/usb_dc_host_end.sv ----
// Purpose: microprocessor end: Wishbone orders turned into link cycles
// Assumes: classic Wishbone slave, word registers, low byte lane enables writes
// Notes: refused accesses are acked without a link cycle and flagged
`timescale 1ns/1ps
module usb_dc_host_end
    import usb_dc_pkg::*;
#(
    parameter int MAX_WORDS = BUF_MAX_WORDS
)(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    usb_dc_link_if.host_mp lnk
);
    localparam int CW = $clog2(MAX_WORDS + 1);

    host_state_t st_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic cmd_sel_r;
    logic wr_r;
    logic rd_r;
    logic dack_r;
    logic eot_r;
    logic [15:0] wd_r;
    logic [7:0] last_r;
    logic [CW-1:0] words_r;
    logic eot_seen_r;
    logic refused_r;
    logic in_dir_r;
    logic req;
    logic wr_en;
    logic cmd_w;
    logic st_w;
    logic data_acc;
    logic dma_a;
    logic refuse;
    logic lk_go;
    logic [15:0] wd_nxt;
    logic [31:0] rd_val;

    assign req = wb_cyc_i && wb_stb_i && (st_r == H_IDLE);
    assign wr_en = wb_we_i && wb_sel_i[0];
    assign cmd_w = wr_en && (wb_adr_i == WB_CMD);
    assign st_w = req && wr_en && (wb_adr_i == WB_STATUS);
    assign data_acc = (wr_en && (wb_adr_i == WB_WDATA)) || (!wb_we_i && (wb_adr_i == WB_RDATA));
    assign dma_a = (wb_adr_i == WB_DMA) && (wr_en || !wb_we_i);
    assign refuse = data_acc ? ((is_one_word(last_r) && (words_r != '0))
                    || ((is_buf_wr(last_r) || is_buf_rd(last_r))
                        && (words_r >= CW'(MAX_WORDS)))
                    || (wb_we_i ? is_buf_rd(last_r) : is_buf_wr(last_r)))
                    : !lnk.dma_req;
    assign lk_go = req && (cmd_w || ((data_acc || dma_a) && !refuse));

    always_comb begin
        wd_nxt = wb_dat_i[15:0];
        if (cmd_w) begin
            wd_nxt = {8'h00, wb_dat_i[7:0]};
        end else if (data_acc && (last_r == CMD_CFG_WR) && in_dir_r) begin
            wd_nxt[CFG_SHORT_BIT] = 1'b0;
        end
        rd_val = 32'h0000_0000;
        if (wb_adr_i == WB_STATUS) begin
            rd_val[ST_DREQ] = lnk.dma_req;
            rd_val[ST_EOT] = eot_seen_r;
            rd_val[ST_REFUSED] = refused_r;
            rd_val[ST_IN_DIR] = in_dir_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st_r <= H_IDLE;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            unique case (st_r)
                H_IDLE: begin
                    if (lk_go && !wb_we_i) begin
                        st_r <= H_WAIT;
                    end else if (req) begin
                        st_r <= H_ACK;
                        ack_r <= 1'b1;
                        dat_r <= rd_val;
                    end
                end
                H_WAIT: begin
                    if (lnk.rvalid) begin
                        st_r <= H_ACK;
                        ack_r <= 1'b1;
                        dat_r <= {16'h0000, lnk.rdata};
                    end
                end
                H_ACK: begin
                    st_r <= H_IDLE;
                    ack_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cmd_sel_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            dack_r <= 1'b0;
            eot_r <= 1'b0;
            wd_r <= 16'h0000;
        end else begin
            cmd_sel_r <= lk_go && cmd_w;
            wr_r <= lk_go && wb_we_i;
            rd_r <= lk_go && !wb_we_i;
            dack_r <= lk_go && dma_a;
            eot_r <= st_w && wb_dat_i[ST_EXT_EOT];
            if (lk_go) begin
                wd_r <= wd_nxt;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            last_r <= 8'h00;
            words_r <= '0;
        end else if (lk_go && cmd_w) begin
            last_r <= wb_dat_i[7:0];
            words_r <= '0;
        end else if (lk_go && data_acc) begin
            words_r <= words_r + 1'b1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            eot_seen_r <= 1'b0;
            refused_r <= 1'b0;
            in_dir_r <= 1'b0;
        end else begin
            if (lnk.eot_dev) begin
                eot_seen_r <= 1'b1;
            end else if (st_w && wb_dat_i[ST_EOT]) begin
                eot_seen_r <= 1'b0;
            end
            if (req && (data_acc || dma_a) && refuse) begin
                refused_r <= 1'b1;
            end else if (st_w && wb_dat_i[ST_REFUSED]) begin
                refused_r <= 1'b0;
            end
            if (st_w) begin
                in_dir_r <= wb_dat_i[ST_IN_DIR];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign lnk.cmd_sel = cmd_sel_r;
    assign lnk.wr_strobe = wr_r;
    assign lnk.rd_strobe = rd_r;
    assign lnk.dma_ack = dack_r;
    assign lnk.eot_host = eot_r;
    assign lnk.wdata = wd_r;
endmodule

// ---- verification/usb_dc_link_asserts.sv ----
// Purpose: link checks between the two ends
// Assumes: one clock, synchronous active-low reset
// Notes: watches the link wires only, so storage side effects are left to the bench
`timescale 1ns/1ps
module usb_dc_link_asserts (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic cmd_sel,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic dma_ack,
    input wire logic eot_host,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic dma_req,
    input wire logic eot_dev
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    a_read_answered: assert property (rd_strobe && !cmd_sel |=> rvalid)
        else $error("read strobe left unanswered");
    a_rvalid_cause: assert property (rvalid |-> $past(rd_strobe && !cmd_sel))
        else $error("answer without a read strobe");
    a_rvalid_single: assert property (rvalid |=> !rvalid)
        else $error("answer longer than one cycle");
    a_rdata_held: assert property ($changed(rdata) |-> rvalid || rdata == 16'h0000)
        else $error("read data moved without an answer");
    a_eot_single: assert property (eot_dev |=> !eot_dev)
        else $error("end of transfer longer than one cycle");
    a_strobe_gap: assert property ((wr_strobe || rd_strobe) |=>
        !(wr_strobe || rd_strobe) [*2])
        else $error("link strobes too close");
    a_strobe_excl: assert property (!(wr_strobe && rd_strobe))
        else $error("read and write strobe together");
    a_dma_qualified: assert property (dma_ack |-> (wr_strobe || rd_strobe) && !cmd_sel
        && ($past(dma_req) || $past(dma_req, 2)))
        else $error("dma access without request");
    a_host_eot_single: assert property (eot_host |=> !eot_host)
        else $error("external stop longer than one cycle");
    a_cmd_high_zero: assert property (cmd_sel |-> wdata[15:8] == 8'h00)
        else $error("command code with upper byte set");
endmodule

// ---- verification/usb_device_dma_and_endpoint_access_test.sv ----
// Purpose: drives both ends over Wishbone and the endpoint side
// Assumes: a storage word reads back its own pointer
// Notes: ep_words_i of 2 forces a primary end on every second DMA word
`timescale 1ns/1ps
module usb_device_dma_and_endpoint_access_test import usb_dc_pkg::*; ;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, usb_rst = 1'b0, short_pkt = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h0, q, wb_q;
    logic ack, sec, wen, commit, sclr, crst;
    logic [3:0] ep;
    logic [9:0] addr, waddr, lasta;
    logic [15:0] wdat, lastw;
    int n_fail = 0, check_count = 0, n_commit = 0, n_clr = 0, n_crst = 0;
    usb_dc_link_if lnk ();
    usb_dc_host_end u_usb_dc_host_end (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_q), .wb_ack_o(ack), .lnk(lnk.host_mp));
    usb_dc_dev_end u_usb_dc_dev_end (.clock_i(clock_i), .rstn_i(rstn_i), .lnk(lnk.dev_mp),
        .usb_reset_i(usb_rst), .short_pkt_i(short_pkt), .buf_eop_i(1'b0), .ep_double_i(1'b1),
        .ep_words_i(10'h002), .buf_rdata_i({ep, sec, 1'b0, addr}), .ep_status_i(8'h5a),
        .buf_ep_o(ep), .buf_addr_o(addr), .buf_waddr_o(waddr), .buf_sec_o(sec),
        .buf_we_o(wen), .buf_wdata_o(wdat), .buf_commit_o(commit), .status_clr_o(sclr),
        .ctrl_reset_o(crst));
    usb_dc_link_asserts u_usb_dc_link_asserts (.clock_i(clock_i), .rstn_i(rstn_i),
        .cmd_sel(lnk.cmd_sel), .wr_strobe(lnk.wr_strobe), .rd_strobe(lnk.rd_strobe),
        .dma_ack(lnk.dma_ack), .eot_host(lnk.eot_host), .wdata(lnk.wdata),
        .rdata(lnk.rdata), .rvalid(lnk.rvalid), .dma_req(lnk.dma_req), .eot_dev(lnk.eot_dev));
    initial forever #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (wen === 1'b1) begin
            lasta <= waddr;
            lastw <= wdat;
        end
        n_commit <= n_commit + (commit === 1'b1);
        n_clr <= n_clr + (sclr === 1'b1);
        n_crst <= n_crst + (crst === 1'b1);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Trailing idle edges let storage writes and pulses land before any check
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do @(posedge clock_i); while (ack !== 1'b1);
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        wb(1'b1, WB_CMD, {24'h0, c});
        wb(1'b0, WB_RDATA, 32'h0);
        chk(q[15:0], exp);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        wb(1'b1, WB_CMD, {24'h0, c});
        wb(1'b1, WB_WDATA, {16'h0, d});
    endtask
    task automatic dma_wr(input logic [15:0] d);
        do wb(1'b0, WB_STATUS, 32'h0); while (q[0] !== 1'b1);
        wb(1'b1, WB_DMA, {16'h0, d});
    endtask
    task automatic t_regs();
        rd(CMD_CFG_RD, CFG_RESET);
        rd(CMD_CNT_RD, CNT_RESET);
        wr(CMD_CFG_WR, 16'hf7f7);
        rd(CMD_CFG_RD, 16'hf6f7);
    endtask
    task automatic t_dma();
        wr(CMD_CNT_WR, 16'h0005);
        rd(CMD_CNT_RD, 16'h0005);
        wr(CMD_CFG_WR, 16'h8038);
        dma_wr(16'h1234);
        chk(lasta, 10'h001);
        chk(lastw, 16'h1234);
        chk(ep, 4'h3);
        rd(CMD_CNT_RD, 16'h0003);
        rd(CMD_CFG_RD, 16'h8138);
        dma_wr(16'h5678);
        chk(n_commit, 1);
        dma_wr(16'h9abc);
        chk(lasta, 10'h001);
        chk(sec, 1'b1);
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[1], 1'b1);
        rd(CMD_CFG_RD, 16'h8030);
    endtask
    task automatic t_reload();
        wr(CMD_CFG_WR, 16'h8038);
        rd(CMD_CNT_RD, 16'h0005);
        usb_rst <= 1'b1;
        @(posedge clock_i);
        usb_rst <= 1'b0;
        rd(CMD_CFG_RD, 16'h8030);
        rd(CMD_CNT_RD, 16'h0005);
    endtask
    task automatic t_short();
        wb(1'b1, WB_STATUS, 32'h6);
        wr(CMD_CFG_WR, 16'h4038);
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[1], 1'b0);
        short_pkt <= 1'b1;
        @(posedge clock_i);
        short_pkt <= 1'b0;
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[1], 1'b1);
    endtask
    task automatic t_buffer();
        for (int c = 1; c < 32; c++) begin
            if (c != 17) begin
                wb(1'b1, WB_CMD, c);
                if (c < 16) begin
                    wb(1'b1, WB_WDATA, 32'h0002);
                    wb(1'b1, WB_WDATA, 32'hbbaa);
                    chk(lasta, 10'h001);
                    chk(lastw, 16'hbbaa);
                end else begin
                    wb(1'b0, WB_RDATA, 32'h0);
                    chk(q[9:0], 10'h000);
                    wb(1'b0, WB_RDATA, 32'h0);
                    chk(q[9:0], 10'h001);
                end
            end
        end
        wb(1'b1, WB_CMD, 32'h02);
        wb(1'b0, WB_RDATA, 32'h0);
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[2], 1'b1);
    endtask
    task automatic t_status();
        for (int c = 80; c < 96; c++) begin
            rd(c[7:0], 16'h005a);
        end
        chk(n_clr, 16);
    endtask
    task automatic t_soft();
        wr(CMD_CFG_WR, 16'h8038);
        wb(1'b1, WB_CMD, {24'h0, CMD_DEV_RESET});
        chk(n_crst, 1);
        rd(CMD_CFG_RD, CFG_RESET);
        rd(CMD_CNT_RD, CNT_RESET);
    endtask
    task automatic t_ext();
        wb(1'b1, WB_STATUS, 32'h4);
        wr(CMD_CNT_WR, 16'h0004);
        wb(1'b1, WB_WDATA, 32'h9);
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[2], 1'b1);
        wb(1'b1, WB_STATUS, 32'hc);
        wr(CMD_CFG_WR, 16'h4038);
        rd(CMD_CFG_RD, 16'h0038);
        wb(1'b1, WB_STATUS, 32'h10);
        chk(n_commit, 2);
        rd(CMD_CFG_RD, 16'h0030);
        wb(1'b1, WB_CMD, 32'h1);
        repeat (513) wb(1'b1, WB_WDATA, 32'h0);
        chk(lasta, 10'h200);
        wb(1'b1, WB_WDATA, 32'h0);
        wb(1'b0, WB_STATUS, 32'h0);
        chk(q[2], 1'b1);
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs();
        t_dma();
        t_reload();
        t_short();
        t_buffer();
        t_status();
        t_soft();
        t_ext();
        tally_and_finish();
    end
endmodule
